//--- design/dmst_map.vh
`ifndef DMST_MAP_VH
`define DMST_MAP_VH

// Register indices, byte address is four times the index
`define DMST_IDX_CFG 8'hBF
`define DMST_IDX_KEY 8'hF6
`define DMST_IDX_STAT 8'h01

// Configuration register layout and reset
`define DMST_CFG_AUXEN_BIT 4
`define DMST_CFG_RST 8'h00
`define DMST_CFG_WMASK 8'h9F
`define DMST_KEY_RST 8'h00

// Key sequence values
`define DMST_KEY_FIRST 8'h87
`define DMST_KEY_SECOND 8'h59
`define DMST_KEY_LOCK 8'h00

// Status register bit positions
`define DMST_STAT_AUXEN_BIT 0
`define DMST_STAT_UNLK_BIT 1
`define DMST_STAT_BUSY_BIT 2
`define DMST_STAT_EXTSEL_BIT 3

// Address space limits
`define DMST_AUX_TOP_HI 8'h00
`define DMST_AUX_DEPTH 256

// Pointer selection codes
`define DMST_PSEL_PTR0 2'h0
`define DMST_PSEL_PTR1 2'h1
`define DMST_PSEL_DPP 2'h2

// Timing counts in oscillator clocks, reset hold count in machine cycles
`define DMST_OSC_DIV 2
`define DMST_ALE_DIV 6
`define DMST_MC_CLKS 12
`define DMST_RST_HOLD_MC 2
`define DMST_RST_HOLD_CLKS (`DMST_RST_HOLD_MC * `DMST_MC_CLKS)

`endif

//--- design/dmst_aux_ram.v
`timescale 1ns/10ps
// Auxiliary data store, flip-flop array with registered read
module dmst_aux_ram #(
  parameter DEPTH = 256,
  parameter AW = 8,
  parameter DW = 8
) (
  input wire clk_i,
  input wire we_i,
  input wire [AW-1:0] addr_i,
  input wire [DW-1:0] wdata_i,
  output reg [DW-1:0] rdata_o
);

  reg [DW-1:0] mem_q [0:DEPTH-1];

  // Read then write port, read returns old contents on a write
  always @(posedge clk_i) begin
    if (we_i) begin
      mem_q[addr_i] <= wdata_i;
    end
    rdata_o <= mem_q[addr_i];
  end

endmodule

//--- design/dmst_top.v
`timescale 1ns/10ps
`include "dmst_map.vh"

// Data move steering and external bus sequencer
module dmst_top #(
  parameter ROM_BYTES = 32768,
  parameter RST_HOLD = `DMST_RST_HOLD_CLKS
) (
  input wire clk_i,
  input wire rst_i,
  // Register bus
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [9:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Core data move requests
  input wire xdm_req_i,
  input wire xdm_we_i,
  input wire [1:0] xdm_psel_i,
  input wire [7:0] ptr0_i,
  input wire [7:0] ptr1_i,
  input wire [15:0] dpp_i,
  input wire [7:0] xdm_wdata_i,
  output reg xdm_done_o,
  output reg [7:0] xdm_rdata_o,
  output reg xdm_aux_o,
  // Core code fetch requests
  input wire fetch_req_i,
  input wire [15:0] fetch_addr_i,
  output reg fetch_done_o,
  output reg [7:0] fetch_data_o,
  output reg fetch_int_o,
  // Port latches from the core
  input wire [7:0] lad_latch_i,
  input wire [7:0] hap_latch_i,
  // Pins
  input wire external_fetch_select_n_i,
  output reg ale_o,
  output reg program_fetch_strobe_n_o,
  output reg rd_n_o,
  output reg wr_n_o,
  input wire [7:0] lad_i,
  output reg [7:0] lad_o,
  output reg [7:0] lad_oe_o,
  output reg [7:0] hap_o,
  output reg [7:0] hap_oe_o
);

  // Bus slot kinds
  localparam [2:0] CYC_IDLE = 3'd0;
  localparam [2:0] CYC_XRD = 3'd1;
  localparam [2:0] CYC_XWR = 3'd2;
  localparam [2:0] CYC_FEXT = 3'd3;
  localparam [2:0] CYC_FINT = 3'd4;

  // Key states
  localparam [1:0] KEY_LOCKED = 2'd0;
  localparam [1:0] KEY_FIRST = 2'd1;
  localparam [1:0] KEY_OPEN = 2'd2;

  localparam [1:0] ST_LAST = 2'd2;
  localparam [31:0] ROM_LIMIT = ROM_BYTES;

  // True for slot kinds that run on the pins
  function is_ext;
    input [2:0] cyc;
    begin
      is_ext = (cyc == CYC_XRD) || (cyc == CYC_XWR) || (cyc == CYC_FEXT);
    end
  endfunction

  // Register index match on a word-aligned address
  function idx_hit;
    input [9:0] adr;
    input [7:0] idx;
    begin
      idx_hit = (adr[9:2] == idx) && (adr[1:0] == 2'b00);
    end
  endfunction

  reg [RST_HOLD-1:0] rst_sh_q;
  reg ph_q;
  reg [1:0] st_q;
  reg [2:0] cyc_q;
  reg [15:0] adr_q;
  reg [7:0] wdat_q;
  reg [7:0] cfg_q;
  reg [1:0] key_q;
  reg aux_pend_q;
  reg [7:0] lad_d;
  reg [7:0] lad_oe_d;
  reg [7:0] hap_d;
  reg [7:0] hap_oe_d;
  reg ph_d;
  reg [1:0] st_d;
  reg [2:0] cyc_d;
  reg [15:0] adr_d;
  wire srst;
  wire bnd;
  wire aux_en;
  wire key_open;
  wire [15:0] xdm_addr;
  wire xdm_ptr8;
  wire route_aux;
  wire xdm_idle;
  wire take_aux;
  wire take_ext;
  wire fetch_take;
  wire fetch_internal;
  wire [7:0] aux_rdata;
  wire wb_req;
  wire wb_wr;
  wire [31:0] rd_word;

  // Reset qualifier, reset only after a long enough high level
  always @(posedge clk_i) begin
    rst_sh_q <= {rst_sh_q[RST_HOLD-2:0], rst_i};
  end
  assign srst = &rst_sh_q;

  // Slot boundary: last clock of the third phase pair
  assign bnd = ph_q && (st_q == ST_LAST);
  assign aux_en = cfg_q[`DMST_CFG_AUXEN_BIT];
  assign key_open = (key_q == KEY_OPEN);

  // Data move address from pointer zero, one or the pair
  assign xdm_ptr8 = (xdm_psel_i != `DMST_PSEL_DPP);
  assign xdm_addr = (xdm_psel_i == `DMST_PSEL_DPP) ? dpp_i :
                    (xdm_psel_i == `DMST_PSEL_PTR1) ? {hap_latch_i, ptr1_i} :
                    {hap_latch_i, ptr0_i};

  // Steering: pointer moves or low addresses go on chip when enabled
  assign route_aux = aux_en &&
                     (xdm_ptr8 || (dpp_i[15:8] == `DMST_AUX_TOP_HI));
  assign xdm_idle = !xdm_done_o && !aux_pend_q &&
                    (cyc_q != CYC_XRD) && (cyc_q != CYC_XWR);
  assign take_aux = xdm_req_i && xdm_idle && route_aux;
  assign take_ext = xdm_req_i && xdm_idle && !route_aux && bnd;
  assign fetch_take = fetch_req_i && !fetch_done_o && !take_ext && bnd &&
                      (cyc_q != CYC_FEXT) && (cyc_q != CYC_FINT);
  assign fetch_internal = external_fetch_select_n_i &&
                          ({16'h0000, fetch_addr_i} < ROM_LIMIT);

  // On-chip auxiliary store, index is the low address byte
  dmst_aux_ram #(
    .DEPTH(`DMST_AUX_DEPTH),
    .AW(8),
    .DW(8)
  ) u_aux (
    .clk_i(clk_i),
    .we_i(take_aux && xdm_we_i),
    .addr_i(xdm_addr[7:0]),
    .wdata_i(xdm_wdata_i),
    .rdata_o(aux_rdata)
  );

  // Phase divider and slot sequencer, next state
  always @* begin
    ph_d = ~ph_q;
    st_d = st_q;
    cyc_d = cyc_q;
    adr_d = adr_q;
    if (ph_q) begin
      st_d = (st_q == ST_LAST) ? 2'd0 : st_q + 2'd1;
    end
    if (bnd) begin
      cyc_d = CYC_IDLE;
      if (take_ext) begin
        cyc_d = xdm_we_i ? CYC_XWR : CYC_XRD;
        adr_d = xdm_addr;
      end else if (fetch_take) begin
        cyc_d = fetch_internal ? CYC_FINT : CYC_FEXT;
        adr_d = fetch_addr_i;
      end
    end
  end

  // Pin values for the next clock
  always @* begin
    lad_d = 8'h00;
    lad_oe_d = ~lad_latch_i;
    hap_d = hap_latch_i;
    hap_oe_d = ~hap_latch_i;
    if (is_ext(cyc_d)) begin
      hap_d = adr_d[15:8];
      hap_oe_d = 8'hFF;
      if (st_d == 2'd0) begin
        lad_d = adr_d[7:0];
        lad_oe_d = 8'hFF;
      end else if (cyc_d == CYC_XWR) begin
        lad_d = wdat_q;
        lad_oe_d = 8'hFF;
      end else begin
        lad_oe_d = 8'h00;
      end
    end
  end

  // Sequencer state and captured write data
  always @(posedge clk_i) begin
    if (srst) begin
      ph_q <= 1'b0;
      st_q <= 2'd0;
      cyc_q <= CYC_IDLE;
      adr_q <= 16'h0000;
      wdat_q <= 8'h00;
    end else begin
      ph_q <= ph_d;
      st_q <= st_d;
      cyc_q <= cyc_d;
      adr_q <= adr_d;
      if (take_ext) begin
        wdat_q <= xdm_wdata_i;
      end
    end
  end

  // Pin registers, auxiliary traffic never reaches them
  always @(posedge clk_i) begin
    if (srst) begin
      ale_o <= 1'b0;
      program_fetch_strobe_n_o <= 1'b1;
      rd_n_o <= 1'b1;
      wr_n_o <= 1'b1;
      lad_o <= 8'h00;
      lad_oe_o <= 8'h00;
      hap_o <= 8'hFF;
      hap_oe_o <= 8'h00;
    end else begin
      ale_o <= (st_d == 2'd0) && !ph_d;
      program_fetch_strobe_n_o <= !((cyc_d == CYC_FEXT) && (st_d != 2'd0));
      rd_n_o <= !((cyc_d == CYC_XRD) && (st_d != 2'd0));
      wr_n_o <= !((cyc_d == CYC_XWR) && (st_d != 2'd0));
      lad_o <= lad_d;
      lad_oe_o <= lad_oe_d;
      hap_o <= hap_d;
      hap_oe_o <= hap_oe_d;
    end
  end

  // Completion of data moves, on chip or on the pins
  always @(posedge clk_i) begin
    if (srst) begin
      aux_pend_q <= 1'b0;
      xdm_done_o <= 1'b0;
      xdm_rdata_o <= 8'h00;
      xdm_aux_o <= 1'b0;
    end else begin
      aux_pend_q <= take_aux;
      xdm_done_o <= 1'b0;
      if (aux_pend_q) begin
        xdm_done_o <= 1'b1;
        xdm_rdata_o <= aux_rdata;
        xdm_aux_o <= 1'b1;
      end else if (bnd && ((cyc_q == CYC_XRD) || (cyc_q == CYC_XWR))) begin
        xdm_done_o <= 1'b1;
        xdm_aux_o <= 1'b0;
        if (cyc_q == CYC_XRD) begin
          xdm_rdata_o <= lad_i;
        end
      end
    end
  end

  // Completion of code fetches
  always @(posedge clk_i) begin
    if (srst) begin
      fetch_done_o <= 1'b0;
      fetch_data_o <= 8'h00;
      fetch_int_o <= 1'b0;
    end else begin
      fetch_done_o <= 1'b0;
      if (bnd && (cyc_q == CYC_FEXT)) begin
        fetch_done_o <= 1'b1;
        fetch_data_o <= lad_i;
        fetch_int_o <= 1'b0;
      end else if (bnd && (cyc_q == CYC_FINT)) begin
        fetch_done_o <= 1'b1;
        fetch_int_o <= 1'b1;
      end
    end
  end

  // Bus slave request decode, writes land on the acknowledged edge
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];

  // Read data mux, unmapped words read zero
  assign rd_word = idx_hit(wb_adr_i, `DMST_IDX_CFG) ? {24'h000000, cfg_q} :
                   idx_hit(wb_adr_i, `DMST_IDX_KEY) ? {30'h0, key_q} :
                   idx_hit(wb_adr_i, `DMST_IDX_STAT) ?
                   {28'h0000000, !external_fetch_select_n_i,
                    is_ext(cyc_q), key_open, aux_en} : 32'h00000000;

  // Acknowledge and read data, one cycle after the strobe
  always @(posedge clk_i) begin
    if (srst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req) begin
        wb_dat_o <= rd_word;
      end
    end
  end

  // Key sequence for configuration writes
  always @(posedge clk_i) begin
    if (srst) begin
      key_q <= KEY_LOCKED;
    end else if (wb_wr && idx_hit(wb_adr_i, `DMST_IDX_KEY)) begin
      case (wb_dat_i[7:0])
        `DMST_KEY_LOCK: key_q <= KEY_LOCKED;
        `DMST_KEY_FIRST: key_q <= KEY_FIRST;
        `DMST_KEY_SECOND: key_q <= (key_q == KEY_FIRST) ? KEY_OPEN : key_q;
        default: key_q <= (key_q == KEY_OPEN) ? KEY_OPEN : KEY_LOCKED;
      endcase
    end
  end

  // Configuration register, cleared on every qualified reset
  always @(posedge clk_i) begin
    if (srst) begin
      cfg_q <= `DMST_CFG_RST;
    end else if (wb_wr && key_open && idx_hit(wb_adr_i, `DMST_IDX_CFG)) begin
      cfg_q <= wb_dat_i[7:0] & `DMST_CFG_WMASK;
    end
  end

endmodule

//--- bench/dmst_properties.sv
`timescale 1ns/10ps
// Pin and handshake timing checks
module dmst_properties (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire xdm_done_o,
  input wire xdm_aux_o,
  input wire fetch_done_o,
  input wire fetch_int_o,
  input wire external_fetch_select_n_i,
  input wire ale_o,
  input wire program_fetch_strobe_n_o,
  input wire rd_n_o,
  input wire wr_n_o,
  input wire [7:0] lad_oe_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_ale_rate:
    assert property (ale_o |=> !ale_o [*5] ##1 ale_o) else $error("ale gap");
  chk_ack_once:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
      else $error("ack timing");
  chk_rd_slot:
    assert property ($fell(rd_n_o) |-> !rd_n_o [*4] ##1 (rd_n_o && xdm_done_o))
      else $error("read strobe");
  chk_fetch_slot:
    assert property ($fell(program_fetch_strobe_n_o) |-> !program_fetch_strobe_n_o [*4] ##1
      (program_fetch_strobe_n_o && fetch_done_o && !fetch_int_o))
      else $error("fetch strobe");
  chk_fetch_float:
    assert property (!program_fetch_strobe_n_o |-> lad_oe_o == 8'h00) else $error("port driven");
  chk_wr_drive:
    assert property (!wr_n_o |-> lad_oe_o == 8'hFF) else $error("port released");
  chk_sel_ext:
    assert property (fetch_done_o && !external_fetch_select_n_i |-> !fetch_int_o)
      else $error("internal fetch");
  chk_aux_quiet:
    assert property (xdm_done_o && xdm_aux_o |-> rd_n_o && wr_n_o && program_fetch_strobe_n_o)
      else $error("strobe on chip");
endmodule

bind dmst_top dmst_properties u_dmst_properties (.*);

//--- bench/dmst_ext_mem.sv
`timescale 1ns/10ps
// External memory behind an address latch
module dmst_ext_mem (
  input wire clk_i,
  input wire ale_i,
  input wire rd_n_i,
  input wire wr_n_i,
  input wire program_fetch_strobe_n_i,
  input wire [7:0] lad_i,
  input wire [7:0] hap_i,
  output wire [7:0] lad_o
);
  reg [7:0] mem_q [0:65535];
  reg [15:0] adr_q;
  reg tog_q = 1'b0;
  // Latch the address while ale is high, store writes
  always @(posedge clk_i) begin
    tog_q <= ~tog_q;
    if (ale_i) adr_q <= {hap_i, lad_i};
    if (!wr_n_i) mem_q[adr_q] <= lad_i;
  end
  // Code or data while a strobe is low, else a toggling pattern
  assign lad_o = !program_fetch_strobe_n_i ? (adr_q[7:0] ^ adr_q[15:8] ^ 8'h5A) :
    (!rd_n_i ? mem_q[adr_q] : {8{tog_q}});
endmodule

//--- bench/dmst_tb_top.sv
`timescale 1ns/10ps
// Bench with memory model on the pins
module dmst_tb_top;
  logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic xdm_req_i = 0, xdm_we_i = 0, fetch_req_i = 0, external_fetch_select_n_i = 1;
  logic [9:0] wb_adr_i = 0;
  logic [3:0] wb_sel_i = 4'h1;
  logic [31:0] wb_dat_i = 0;
  logic [1:0] xdm_psel_i = 0;
  logic [7:0] ptr0_i = 0, ptr1_i = 0, xdm_wdata_i = 0, lad_latch_i = 0, hap_latch_i = 0, q, d;
  logic [15:0] dpp_i = 0, fetch_addr_i = 0, a;
  wire [31:0] wb_dat_o;
  wire wb_ack_o, xdm_done_o, xdm_aux_o, fetch_done_o, fetch_int_o, ale_o;
  wire program_fetch_strobe_n_o, rd_n_o, wr_n_o;
  wire [7:0] xdm_rdata_o, fetch_data_o, lad_i, lad_o, lad_oe_o, hap_o, hap_oe_o, mem_lad;
  int err_count = 0, n_compared = 0, cycles = 0, i;
  logic aux;
  // Clock and low port wire level
  always #2 clk_i = ~clk_i;
  assign lad_i = (lad_oe_o & lad_o) | (~lad_oe_o & mem_lad);
  dmst_top #(.RST_HOLD(4)) u_dmst_top (.*);
  dmst_ext_mem u_dmst_ext_mem (.clk_i(clk_i), .ale_i(ale_o), .rd_n_i(rd_n_o), .wr_n_i(wr_n_o),
    .program_fetch_strobe_n_i(program_fetch_strobe_n_o), .lad_i(lad_i), .hap_i(hap_o | ~hap_oe_o),
    .lad_o(mem_lad));
  function automatic [7:0] exp_code(input [15:0] x);
    exp_code = x[7:0] ^ x[15:8] ^ 8'h5A;
  endfunction
  task chk(input logic [15:0] s, e);
    n_compared++;
    if (s !== e) begin
      err_count++;
      $display("Error %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task wrap_up;
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // One classic bus cycle
  task wb(input bit w, input [9:0] ad, input [7:0] dt);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= w;
    wb_adr_i <= ad;
    wb_dat_i <= {24'h0, dt};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1 && ++n < 64);
    if (n >= 64) err_count++;
    q = wb_dat_o[7:0];
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
  endtask
  task unlock;
    wb(1, 10'h3D8, 8'h87);
    wb(1, 10'h3D8, 8'h59);
  endtask
  // Data move at address a, or at its low byte under hap_latch_i for pointer selects, unused pointers hold the inverse
  task xm(input bit w, input [1:0] s, input [7:0] dt);
    int n;
    n = 0;
    @(posedge clk_i);
    xdm_req_i <= 1;
    xdm_we_i <= w;
    xdm_psel_i <= s;
    ptr0_i <= (s == 0) ? a[7:0] : ~a[7:0];
    ptr1_i <= (s == 1) ? a[7:0] : ~a[7:0];
    dpp_i <= (s == 2) ? a : ~a;
    xdm_wdata_i <= dt;
    do @(posedge clk_i); while (xdm_done_o !== 1'b1 && ++n < 64);
    if (n >= 64) err_count++;
    q = xdm_rdata_o;
    aux = xdm_aux_o;
    xdm_req_i <= 0;
  endtask
  task ft(input [15:0] fa);
    int n;
    n = 0;
    @(posedge clk_i);
    fetch_req_i <= 1;
    fetch_addr_i <= fa;
    do @(posedge clk_i); while (fetch_done_o !== 1'b1 && ++n < 64);
    if (n >= 64) err_count++;
    q = fetch_data_o;
    aux = fetch_int_o;
    fetch_req_i <= 0;
  endtask
  // Hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      wrap_up;
    end
  end
  // Main sequence
  initial begin
    void'($urandom(32'h1734));
    lad_latch_i <= $urandom;
    hap_latch_i <= $urandom;
    repeat (16) @(posedge clk_i);
    rst_i <= 0;
    repeat (2) @(posedge clk_i);
    wb(0, 10'h2FC, 0);
    chk(q, 8'h00);
    wb(0, 10'h3FC, 0);
    chk(q, 8'h00);
    wb(1, 10'h2FC, 8'h10);
    wb(0, 10'h2FC, 0);
    chk(q, 8'h00);
    unlock;
    wb(0, 10'h3D8, 0);
    chk(q, 8'h02);
    wb(1, 10'h2FC, 8'h10);
    wb(1, 10'h3D8, 8'h00);
    wb(0, 10'h3D8, 0);
    chk(q, 8'h00);
    wb(1, 10'h2FC, 8'h00);
    wb(0, 10'h2FC, 0);
    chk(q, 8'h10);
    rst_i <= 1;
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    wb(0, 10'h2FC, 0);
    chk(q, 8'h10);
    for (i = 0; i < 12; i++) begin
      a = (i < 6) ? 16'($urandom % 256) : 16'($urandom_range(65535, 256));
      if (i % 6 == 0) a = (i == 0) ? 16'h00FF : 16'h0100;
      d = $urandom;
      xm(1, (i < 6) ? 2'(i % 3) : 2'd2, d);
      chk(aux, i < 6);
      if (i >= 6) chk(u_dmst_ext_mem.adr_q, a);
      xm(0, (i < 6) ? 2'((i + 1) % 3) : 2'd2, 0);
      chk(q, d);
    end
    ft(16'h0123);
    chk(aux, 1'b1);
    ft(16'h8123);
    chk(q, exp_code(16'h8123));
    external_fetch_select_n_i <= 0;
    ft(16'h0042);
    chk(aux, 1'b0);
    chk(q, exp_code(16'h0042));
    unlock;
    wb(1, 10'h2FC, 8'h00);
    wb(0, 10'h004, 0);
    chk(q, 8'h0A);
    a = 16'h0034;
    xm(1, 0, 8'hA5);
    chk(aux, 1'b0);
    chk(u_dmst_ext_mem.adr_q, {hap_latch_i, 8'h34});
    rst_i <= 1;
    repeat (16) @(posedge clk_i);
    rst_i <= 0;
    repeat (2) @(posedge clk_i);
    wb(0, 10'h2FC, 0);
    chk(q, 8'h00);
    wrap_up;
  end
endmodule
